// [hw/sync_cfg_params.svh]
// Offsets, field positions, reset values and timing figures of the register group
`ifndef SYNC_CFG_PARAMS_SVH
`define SYNC_CFG_PARAMS_SVH
`define OFS_SYNC_WIDTH_LOW 8'h0d
`define OFS_SYNC_DELAY_MID 8'h0e
`define OFS_SYNC_DELAY_LOW 8'h0f
`define OFS_COARSE_PHASE 8'h10
`define OFS_FINE_LAT_HIGH 8'h11
`define OFS_FINE_LAT_LOW 8'h12
`define OFS_MONITOR_CFG 8'h13
`define OFS_PIN_ROUTE 8'h14
`define RST_SYNC_WIDTH_LOW 8'h01
`define RST_SYNC_DELAY_MID 8'h00
`define RST_SYNC_DELAY_LOW 8'h00
`define RST_COARSE_PHASE 8'h00
`define RST_FINE_LAT_HIGH 8'h80
`define RST_FINE_LAT_LOW 8'h00
`define RST_MONITOR_CFG 8'h00
`define RST_PIN_ROUTE 8'h3c
`define LAT_COMMIT_BIT 7
`define OFS_GLOBAL_EN_BIT 7
`define OFS_THR_MSB 6
`define OFS_THR_LSB 5
`define VALID_HOLD_MSB 4
`define VALID_HOLD_LSB 3
`define SLIP_RETRIG_MSB 2
`define SLIP_RETRIG_LSB 0
`define ROUTE_WR_MASK 8'h3f
`define ROUTE_ALARM_BIT 5
`define ROUTE_IN3_BIT 4
`define ROUTE_IN2_BIT 3
`define ROUTE_IN1_BIT 2
`define ROUTE_LOL_BIT 1
`define ROUTE_INT_BIT 0
`define CLK_MHZ 125
`define VALID_T0_US 2000
`define VALID_T1_US 100000
`define VALID_T2_US 200000
`define VALID_T3_US 13000000
`define SLIP_T0_US 106000
`define SLIP_T1_US 53000
`define SLIP_T2_US 26500
`define SLIP_T3_US 13300
`define SLIP_T4_US 6660
`define SLIP_T5_US 3330
`define SLIP_T6_US 1660
`define SLIP_T7_US 833
`define PHASE_SLEW_S 20
`define PHASE_SLEW_STEPS 256
`endif

// [hw/sync_cfg_pkg.sv]
// Types shared by the register group
package sync_cfg_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [2:0] {
    PIN_OFF = 3'b001,
    PIN_INT = 3'b010,
    PIN_ALARM = 3'b100
  } pin_src_t;
  typedef enum logic [1:0] {
    SLEW_IDLE = 2'b01,
    SLEW_WAIT = 2'b10
  } slew_state_t;
endpackage : sync_cfg_pkg

// [hw/commit_hold.sv]
// Holds a multi-byte value while its commit bit is low
`timescale 1ns/1ps
`default_nettype none
module commit_hold #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_live,
  input wire logic i_commit,
  output logic [W-1:0] o_value
);
  // Follow the live bytes only while committed, else keep the last good value
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_value <= '0;
    else if (i_commit)
      o_value <= i_live;
  end
endmodule : commit_hold
`default_nettype wire

// [hw/hold_timer.sv]
// Reloadable down counter that stays busy for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module hold_timer (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [31:0] i_limit,
  output logic o_busy
);
  logic [31:0] count_q;
  // Reload on each trigger, then count down to zero
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      count_q <= 32'h0;
    else if (i_load)
      count_q <= i_limit;
    else if (count_q != 32'h0)
      count_q <= count_q - 32'h1;
  end
  assign o_busy = (count_q != 32'h0);
endmodule : hold_timer
`default_nettype wire

// [hw/sync_skew_latency_alarm_regs.sv]
// Sync pulse, phase, latency, monitor and pin routing configuration registers
//
// Overview of operation
// [R1] Width low byte, resets to one
// [R2] Delay bits 15:8 and 7:0 in two registers
// [R3] Delay low byte resets to zero
// [R4] Coarse phase used when hardware stepping deselected
// [R5] Coarse phase is signed, -128 to +127
// [R6] Phase shift applied gradually, within twenty seconds
// [R7] Host clears commit before latency bytes, sets after
// [R8] Commit low holds old latency, high passes live
// [R9] Fifteen-bit latency across two registers
// [R10] Latency high register resets with commit set
// [R11] Global enable gates every per-input offset alarm
// [R12] Two-bit offset threshold selects alarm ppm
// [R13] Two-bit valid hold time before alarm clears
// [R14] Three-bit slip monitor retrigger interval
// [R15] Routing top two bits read-only, rest writable
// [R16] Width zero means half duty, else periods
// [R17] Seventeen-bit delay in output clock periods
// [R18] Delay commit low holds old delay value
// [R19] Interrupt routing beats alarm on shared pin
`timescale 1ns/1ps
`default_nettype none
`include "sync_cfg_params.svh"
module sync_skew_latency_alarm_regs #(
  parameter int unsigned VALID_T0_CYC = `VALID_T0_US * `CLK_MHZ,
  parameter int unsigned VALID_T1_CYC = `VALID_T1_US * `CLK_MHZ,
  parameter int unsigned VALID_T2_CYC = `VALID_T2_US * `CLK_MHZ,
  parameter int unsigned VALID_T3_CYC = `VALID_T3_US * `CLK_MHZ,
  parameter int unsigned SLIP_T0_CYC = `SLIP_T0_US * `CLK_MHZ,
  parameter int unsigned SLIP_T1_CYC = `SLIP_T1_US * `CLK_MHZ,
  parameter int unsigned SLIP_T2_CYC = `SLIP_T2_US * `CLK_MHZ,
  parameter int unsigned SLIP_T3_CYC = `SLIP_T3_US * `CLK_MHZ,
  parameter int unsigned SLIP_T4_CYC = `SLIP_T4_US * `CLK_MHZ,
  parameter int unsigned SLIP_T5_CYC = `SLIP_T5_US * `CLK_MHZ,
  parameter int unsigned SLIP_T6_CYC = `SLIP_T6_US * `CLK_MHZ,
  parameter int unsigned SLIP_T7_CYC = `SLIP_T7_US * `CLK_MHZ,
  parameter int unsigned PHASE_STEP_CYC =
    (`PHASE_SLEW_S * 1000000 / `PHASE_SLEW_STEPS) * `CLK_MHZ
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port behind the serial configuration bus
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire sync_cfg_pkg::reg_byte_t i_reg_wdata,
  output sync_cfg_pkg::reg_byte_t o_reg_rdata,
  output logic o_reg_ack,
  // Upper field bits and commit held in the neighbouring register
  input wire logic [1:0] i_sync_width_high,
  input wire logic i_width_update_commit,
  input wire logic i_sync_delay_top,
  input wire logic i_delay_update_commit,
  input wire logic i_hw_phase_step_select,
  input wire logic [3:0] i_per_input_offset_enable,
  input wire logic i_int_pin_route,
  // Status from the clock monitors
  input wire logic [3:0] i_input_valid,
  input wire logic i_phase_slip,
  input wire logic i_alarm_summary,
  input wire logic i_int_status,
  input wire logic [2:0] i_input_fault,
  input wire logic i_lock_loss,
  // Settings delivered to the datapath
  output logic [9:0] o_sync_pulse_width,
  output logic o_sync_half_duty,
  output logic [16:0] o_sync_pulse_delay,
  output logic signed [7:0] o_coarse_output_phase,
  output logic o_phase_slewing,
  output logic [14:0] o_fine_latency_adjust,
  output logic [3:0] o_freq_offset_alarm_en,
  output logic [1:0] o_offset_alarm_threshold,
  output logic [3:0] o_input_alarm,
  output logic o_slip_monitor_busy,
  // Status pins, with output enables
  output logic o_alarm_pin,
  output logic o_alarm_pin_oe,
  output logic [2:0] o_fault_pin,
  output logic [2:0] o_fault_pin_oe,
  output logic o_lock_loss_pin,
  output logic o_lock_loss_pin_oe
);
  import sync_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  reg_byte_t width_low_q;
  reg_byte_t delay_mid_q;
  reg_byte_t delay_low_q;
  reg_byte_t phase_q;
  reg_byte_t lat_high_q;
  reg_byte_t lat_low_q;
  reg_byte_t mon_cfg_q;
  reg_byte_t route_q;
  reg_byte_t rdata_d;
  logic phase_wr_q;

  // Address decode
  wire sel_width_low = (i_reg_addr == `OFS_SYNC_WIDTH_LOW);
  wire sel_delay_mid = (i_reg_addr == `OFS_SYNC_DELAY_MID);
  wire sel_delay_low = (i_reg_addr == `OFS_SYNC_DELAY_LOW);
  wire sel_phase = (i_reg_addr == `OFS_COARSE_PHASE);
  wire sel_lat_high = (i_reg_addr == `OFS_FINE_LAT_HIGH);
  wire sel_lat_low = (i_reg_addr == `OFS_FINE_LAT_LOW);
  wire sel_mon_cfg = (i_reg_addr == `OFS_MONITOR_CFG);
  wire sel_route = (i_reg_addr == `OFS_PIN_ROUTE);

  // Read-only top bits of the routing register keep their stored value
  wire [7:0] route_wr = (route_q & ~`ROUTE_WR_MASK) |
    (i_reg_wdata & `ROUTE_WR_MASK); // R15

  // Sync pulse width and delay bytes
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      width_low_q <= `RST_SYNC_WIDTH_LOW; // R1
      delay_mid_q <= `RST_SYNC_DELAY_MID;
      delay_low_q <= `RST_SYNC_DELAY_LOW; // R3
    end
    else if (i_reg_wr)
    begin
      if (sel_width_low)
        width_low_q <= i_reg_wdata; // R1
      if (sel_delay_mid)
        delay_mid_q <= i_reg_wdata; // R2
      if (sel_delay_low)
        delay_low_q <= i_reg_wdata; // R2
    end
  end

  // Coarse phase and fine latency bytes
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      phase_q <= `RST_COARSE_PHASE;
      lat_high_q <= `RST_FINE_LAT_HIGH; // R10
      lat_low_q <= `RST_FINE_LAT_LOW;
    end
    else if (i_reg_wr)
    begin
      if (sel_phase)
        phase_q <= i_reg_wdata; // R4
      if (sel_lat_high)
        lat_high_q <= i_reg_wdata; // R9
      if (sel_lat_low)
        lat_low_q <= i_reg_wdata; // R9
    end
  end

  // Monitor configuration and pin routing
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      mon_cfg_q <= `RST_MONITOR_CFG;
      route_q <= `RST_PIN_ROUTE;
    end
    else if (i_reg_wr)
    begin
      if (sel_mon_cfg)
        mon_cfg_q <= i_reg_wdata;
      if (sel_route)
        route_q <= route_wr; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: one-cycle answer, zero for unmapped offsets
  always_comb
  begin
    rdata_d = 8'h00;
    if (sel_width_low)
      rdata_d = width_low_q;
    if (sel_delay_mid)
      rdata_d = delay_mid_q;
    if (sel_delay_low)
      rdata_d = delay_low_q;
    if (sel_phase)
      rdata_d = phase_q;
    if (sel_lat_high)
      rdata_d = lat_high_q;
    if (sel_lat_low)
      rdata_d = lat_low_q;
    if (sel_mon_cfg)
      rdata_d = mon_cfg_q;
    if (sel_route)
      rdata_d = route_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_ack <= 1'b0;
      phase_wr_q <= 1'b0;
    end
    else
    begin
      o_reg_rdata <= i_reg_rd ? rdata_d : 8'h00;
      o_reg_ack <= i_reg_rd | i_reg_wr;
      phase_wr_q <= i_reg_wr & sel_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Commit-protected multi-byte values
  wire [9:0] width_live = {i_sync_width_high, width_low_q};
  wire [16:0] delay_live = {i_sync_delay_top, delay_mid_q, delay_low_q};
  wire [14:0] lat_live = {lat_high_q[6:0], lat_low_q}; // R9
  wire lat_commit = lat_high_q[`LAT_COMMIT_BIT];

  commit_hold #(
    .W(10)
  ) u_width_hold (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_live(width_live),
    .i_commit(i_width_update_commit),
    .o_value(o_sync_pulse_width)
  );

  // Delay holds its last value while the host rewrites the bytes
  commit_hold #(
    .W(17)
  ) u_delay_hold (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_live(delay_live), // R17
    .i_commit(i_delay_update_commit), // R18
    .o_value(o_sync_pulse_delay)
  );

  // Latency passes straight through only while committed
  commit_hold #(
    .W(15)
  ) u_lat_hold (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_live(lat_live),
    .i_commit(lat_commit), // R8
    .o_value(o_fine_latency_adjust)
  );

  // Zero width selects half duty cycle, held together with the width
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_sync_half_duty <= 1'b0;
    else if (i_width_update_commit)
      o_sync_half_duty <= (width_live == 10'h000); // R16
  end

  ////////////////////////////////////////////////////////////////////////
  // Coarse phase slew: one step per interval toward the signed target
  slew_state_t slew_q;
  slew_state_t slew_d;
  logic [31:0] slew_cnt_q;
  logic signed [7:0] target_q;
  wire signed [7:0] target = phase_q; // R5
  wire at_target = (o_coarse_output_phase == target_q);
  wire step_due = (slew_cnt_q == 32'h0);

  always_comb
  begin
    slew_d = slew_q;
    unique case (slew_q)
      SLEW_IDLE:
        if (!at_target)
          slew_d = SLEW_WAIT;
      SLEW_WAIT:
        if (at_target)
          slew_d = SLEW_IDLE;
      default:
        slew_d = SLEW_IDLE;
    endcase
  end

  // Software target captured only when hardware stepping is off
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      target_q <= 8'sh00;
    else if (phase_wr_q && !i_hw_phase_step_select)
      target_q <= target; // R4
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      slew_q <= SLEW_IDLE;
      slew_cnt_q <= 32'h0;
      o_coarse_output_phase <= 8'sh00;
    end
    else
    begin
      slew_q <= slew_d;
      if (slew_q == SLEW_IDLE)
        slew_cnt_q <= PHASE_STEP_CYC - 32'h1;
      else if (!step_due)
        slew_cnt_q <= slew_cnt_q - 32'h1;
      else
      begin
        slew_cnt_q <= PHASE_STEP_CYC - 32'h1; // R6
        if (o_coarse_output_phase < target_q)
          o_coarse_output_phase <= o_coarse_output_phase + 8'sh01;
        else if (o_coarse_output_phase > target_q)
          o_coarse_output_phase <= o_coarse_output_phase - 8'sh01;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_phase_slewing <= 1'b0;
    else
      o_phase_slewing <= (slew_d == SLEW_WAIT);
  end

  ////////////////////////////////////////////////////////////////////////
  // Frequency offset alarm enables and threshold
  wire offset_global = mon_cfg_q[`OFS_GLOBAL_EN_BIT];

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_freq_offset_alarm_en <= 4'h0;
      o_offset_alarm_threshold <= 2'h0;
    end
    else
    begin
      o_freq_offset_alarm_en <= {4{offset_global}} &
        i_per_input_offset_enable; // R11
      o_offset_alarm_threshold <=
        mon_cfg_q[`OFS_THR_MSB:`OFS_THR_LSB]; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Valid hold timers: alarm clears after the input stays valid long enough
  wire [1:0] hold_sel = mon_cfg_q[`VALID_HOLD_MSB:`VALID_HOLD_LSB];
  logic [31:0] hold_limit;
  logic [3:0] hold_busy;

  always_comb
  begin
    unique case (hold_sel)
      2'h0: hold_limit = VALID_T0_CYC; // R13
      2'h1: hold_limit = VALID_T1_CYC;
      2'h2: hold_limit = VALID_T2_CYC;
      2'h3: hold_limit = VALID_T3_CYC;
    endcase
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_hold
    hold_timer u_hold (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(!i_input_valid[g]),
      .i_limit(hold_limit),
      .o_busy(hold_busy[g])
    );
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_input_alarm <= 4'h0;
    else
      o_input_alarm <= ~i_input_valid | hold_busy; // R13
  end

  ////////////////////////////////////////////////////////////////////////
  // Slip one-shot, retriggered by each phase slip
  wire [2:0] slip_sel = mon_cfg_q[`SLIP_RETRIG_MSB:`SLIP_RETRIG_LSB];
  logic [31:0] slip_limit;
  logic slip_busy;

  always_comb
  begin
    unique case (slip_sel)
      3'h0: slip_limit = SLIP_T0_CYC; // R14
      3'h1: slip_limit = SLIP_T1_CYC;
      3'h2: slip_limit = SLIP_T2_CYC;
      3'h3: slip_limit = SLIP_T3_CYC;
      3'h4: slip_limit = SLIP_T4_CYC;
      3'h5: slip_limit = SLIP_T5_CYC;
      3'h6: slip_limit = SLIP_T6_CYC;
      3'h7: slip_limit = SLIP_T7_CYC;
    endcase
  end

  hold_timer u_slip (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(i_phase_slip),
    .i_limit(slip_limit),
    .o_busy(slip_busy)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_slip_monitor_busy <= 1'b0;
    else
      o_slip_monitor_busy <= slip_busy | i_phase_slip;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status pin routing
  pin_src_t pin_src;
  wire [2:0] fault_route = {route_q[`ROUTE_IN3_BIT],
    route_q[`ROUTE_IN2_BIT], route_q[`ROUTE_IN1_BIT]};

  // Interrupt request on the shared pin overrides the alarm request
  assign pin_src = i_int_pin_route ? PIN_INT :
    route_q[`ROUTE_ALARM_BIT] ? PIN_ALARM : PIN_OFF; // R19

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_alarm_pin <= 1'b0;
      o_alarm_pin_oe <= 1'b0;
    end
    else
    begin
      o_alarm_pin <= (pin_src == PIN_INT) ? i_int_status :
        (pin_src == PIN_ALARM) & i_alarm_summary; // R19
      o_alarm_pin_oe <= (pin_src != PIN_OFF);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_fault_pin <= 3'h0;
      o_fault_pin_oe <= 3'h0;
      o_lock_loss_pin <= 1'b0;
      o_lock_loss_pin_oe <= 1'b0;
    end
    else
    begin
      o_fault_pin <= i_input_fault & fault_route;
      o_fault_pin_oe <= fault_route;
      o_lock_loss_pin <= i_lock_loss & route_q[`ROUTE_LOL_BIT];
      o_lock_loss_pin_oe <= route_q[`ROUTE_LOL_BIT];
    end
  end
endmodule : sync_skew_latency_alarm_regs
`default_nettype wire

// [sim/sync_regs_props.sv]
// Assertions on the register port, commit holds, phase slew and shared pin
`timescale 1ns/1ps
`default_nettype none
module sync_regs_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire sync_cfg_pkg::reg_byte_t i_reg_wdata,
  input wire sync_cfg_pkg::reg_byte_t o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic i_delay_update_commit,
  input wire logic i_hw_phase_step_select,
  input wire logic [3:0] i_per_input_offset_enable,
  input wire logic i_int_pin_route,
  input wire logic i_int_status,
  input wire logic [16:0] o_sync_pulse_delay,
  input wire logic signed [7:0] o_coarse_output_phase,
  input wire logic o_phase_slewing,
  input wire logic [14:0] o_fine_latency_adjust,
  input wire logic [3:0] o_freq_offset_alarm_en,
  input wire logic [1:0] o_offset_alarm_threshold,
  input wire logic o_alarm_pin,
  input wire logic o_alarm_pin_oe
);
  import sync_cfg_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Decodes and a mirror of the latency commit bit
  wire lat_hi_wr = i_reg_wr && i_reg_addr == 8'h11;
  wire mon_wr = i_reg_wr && i_reg_addr == 8'h13;
  wire phase_wr = i_reg_wr && i_reg_addr == 8'h10 && !i_hw_phase_step_select;
  logic commit_q;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      commit_q <= 1'b1;
    else if (lat_hi_wr)
      commit_q <= i_reg_wdata[7];
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_ACK_NEXT: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
    else $error("ack missing after strobe");
  AST_RDATA_IDLE: assert property (!o_reg_ack |-> o_reg_rdata == 8'h00)
    else $error("read data not zero outside ack");
  AST_GLOBAL_EN: assert property (mon_wr && !i_reg_wdata[7] |-> ##2 o_freq_offset_alarm_en == 4'h0)
    else $error("offset alarms not disabled globally");
  AST_THRESHOLD: assert property (mon_wr |-> ##2 o_offset_alarm_threshold == $past(i_reg_wdata[6:5], 2))
    else $error("threshold field not delivered");
  AST_LAT_HOLD: assert property (!commit_q |=> $stable(o_fine_latency_adjust))
    else $error("latency moved while commit low");
  AST_DELAY_HOLD: assert property (!i_delay_update_commit |=> $stable(o_sync_pulse_delay))
    else $error("delay moved while commit low");
  AST_SHARED_PIN: assert property (i_int_pin_route |=> o_alarm_pin_oe && o_alarm_pin == $past(i_int_status))
    else $error("interrupt route lost priority");
  AST_PHASE_START: assert property (phase_wr && i_reg_wdata != o_coarse_output_phase |-> ##[2:3] o_phase_slewing)
    else $error("phase write did not start slewing");
  AST_PHASE_STEP: assert property ($changed(o_coarse_output_phase) && !$past(i_sys_rst) |-> 8'(o_coarse_output_phase - $past(o_coarse_output_phase)) inside {8'h01, 8'hff})
    else $error("phase moved by more than one step");
  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios reached
  cover property (lat_hi_wr && !i_reg_wdata[7]);
  cover property (o_phase_slewing);
  cover property (i_int_pin_route && o_alarm_pin);
endmodule : sync_regs_props
bind sync_skew_latency_alarm_regs sync_regs_props u_props (.i_clk, .i_sys_rst, .i_reg_addr,
  .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .i_delay_update_commit,
  .i_hw_phase_step_select, .i_per_input_offset_enable, .i_int_pin_route, .i_int_status,
  .o_sync_pulse_delay, .o_coarse_output_phase, .o_phase_slewing, .o_fine_latency_adjust,
  .o_freq_offset_alarm_en, .o_offset_alarm_threshold, .o_alarm_pin, .o_alarm_pin_oe);
`default_nettype wire

// [sim/cfg_host_model.sv]
// Host model issuing single strobe transfers on the register port
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input wire logic i_clk,
  input wire sync_cfg_pkg::reg_byte_t i_rdata,
  input wire logic i_ack,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output sync_cfg_pkg::reg_byte_t o_reg_wdata
);
  import sync_cfg_pkg::*;
  initial
  begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // One-cycle strobe; answer taken in the cycle after, then lines scrambled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = w;
    o_reg_rd = !w;
    @(negedge i_clk);
    q = i_rdata;
    ok = i_ack;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : xfer
endmodule : cfg_host_model
`default_nettype wire

// [sim/sync_skew_latency_alarm_regs_tb.sv]
// Self-checking bench for the sync, latency and alarm configuration group
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module sync_skew_latency_alarm_regs_tb;
  import sync_cfg_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] b;} row_t;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr, i_reg_rd, o_reg_ack;
  logic [7:0] i_reg_addr;
  reg_byte_t i_reg_wdata, o_reg_rdata;
  logic [1:0] i_sync_width_high = 2'b00;
  logic i_width_update_commit = 1'b1, i_sync_delay_top = 1'b1, i_delay_update_commit = 1'b1;
  logic i_hw_phase_step_select = 1'b1, i_int_pin_route = 1'b0, i_phase_slip = 1'b0;
  logic [3:0] i_per_input_offset_enable = 4'b1010, i_input_valid = 4'hf;
  logic i_alarm_summary = 1'b0, i_int_status = 1'b0, i_lock_loss = 1'b0;
  logic [2:0] i_input_fault = 3'b000, o_fault_pin, o_fault_pin_oe;
  logic [9:0] o_sync_pulse_width;
  logic [16:0] o_sync_pulse_delay;
  logic signed [7:0] o_coarse_output_phase;
  logic [14:0] o_fine_latency_adjust;
  logic [3:0] o_freq_offset_alarm_en, o_input_alarm;
  logic [1:0] o_offset_alarm_threshold;
  logic o_sync_half_duty, o_phase_slewing, o_slip_monitor_busy, o_alarm_pin, o_alarm_pin_oe;
  logic o_lock_loss_pin, o_lock_loss_pin_oe;
  row_t rows [8] = '{'{8'h0d, 8'h01, 8'h00, 8'h00}, '{8'h0e, 8'h00, 8'h12, 8'h12},
    '{8'h0f, 8'h00, 8'h34, 8'h34}, '{8'h11, 8'h80, 8'h95, 8'h95}, '{8'h12, 8'h00, 8'h5a, 8'h5a},
    '{8'h13, 8'h00, 8'ha5, 8'ha5}, '{8'h14, 8'h3c, 8'hff, 8'h3f}, '{8'h20, 8'h00, 8'hff, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////
  // Clock, host model and device
  always #4 i_clk = ~i_clk;
  cfg_host_model host (.i_clk, .i_rdata(o_reg_rdata), .i_ack(o_reg_ack), .o_reg_addr(i_reg_addr),
    .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));
  sync_skew_latency_alarm_regs #(.VALID_T1_CYC(30), .SLIP_T7_CYC(20), .PHASE_STEP_CYC(4)) dut (
    .i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
    .o_reg_ack, .i_sync_width_high, .i_width_update_commit, .i_sync_delay_top,
    .i_delay_update_commit, .i_hw_phase_step_select, .i_per_input_offset_enable,
    .i_int_pin_route, .i_input_valid, .i_phase_slip, .i_alarm_summary, .i_int_status,
    .i_input_fault, .i_lock_loss, .o_sync_pulse_width, .o_sync_half_duty, .o_sync_pulse_delay,
    .o_coarse_output_phase, .o_phase_slewing, .o_fine_latency_adjust, .o_freq_offset_alarm_en,
    .o_offset_alarm_threshold, .o_input_alarm, .o_slip_monitor_busy, .o_alarm_pin,
    .o_alarm_pin_oe, .o_fault_pin, .o_fault_pin_oe, .o_lock_loss_pin, .o_lock_loss_pin_oe);
  ////////////////////////////////////////////////////////////////////////////
  // Register access and waiting helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    host.xfer(1'b1, a, d, q, ok);
    `CHK("write ack", 1'b1, ok)
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic ok;
    host.xfer(1'b0, a, 8'h00, q, ok);
    `CHK("read ack", 1'b1, ok)
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Cycle ceiling against a hang
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] q;
    wt(10);
    i_sys_rst = 1'b0;
    foreach (rows[i])
    begin
      rd(rows[i].a, q);
      `CHK("reset value", rows[i].r, q)
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, q);
      `CHK("readback", rows[i].b, q)
    end
    wt(3);
    `CHK("half duty", 1'b1, o_sync_half_duty)
    `CHK("delay", 17'h11234, o_sync_pulse_delay)
    `CHK("latency", 15'h155a, o_fine_latency_adjust)
    `CHK("offset enables", 4'b1010, o_freq_offset_alarm_en)
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h13, {1'b0, 2'(c), 5'b00111});
      wt(2);
      `CHK("threshold", 2'(c), o_offset_alarm_threshold)
      `CHK("offset enables off", 4'h0, o_freq_offset_alarm_en)
    end
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h33);
    wt(2);
    `CHK("latency held", 15'h155a, o_fine_latency_adjust)
    wr(8'h11, 8'h81);
    wt(2);
    `CHK("latency new", 15'h0133, o_fine_latency_adjust)
    i_delay_update_commit = 1'b0;
    wr(8'h0f, 8'h77);
    wt(2);
    `CHK("delay held", 17'h11234, o_sync_pulse_delay)
    i_delay_update_commit = 1'b1;
    wt(2);
    `CHK("delay new", 17'h11277, o_sync_pulse_delay)
    i_sync_width_high = 2'b10;
    wr(8'h0d, 8'h05);
    wt(2);
    `CHK("width", 10'h205, o_sync_pulse_width)
    `CHK("half duty off", 1'b0, o_sync_half_duty)
    i_width_update_commit = 1'b0;
    i_sync_width_high = 2'b00;
    wr(8'h0d, 8'h00);
    wt(2);
    `CHK("half duty held", 1'b0, o_sync_half_duty)
    i_width_update_commit = 1'b1;
    i_hw_phase_step_select = 1'b0;
    wr(8'h10, 8'hfe);
    wt(40);
    `CHK("phase", 8'hfe, o_coarse_output_phase)
    `CHK("slew done", 1'b0, o_phase_slewing)
    i_hw_phase_step_select = 1'b1;
    wr(8'h10, 8'h05);
    wt(20);
    `CHK("phase ignored", 8'hfe, o_coarse_output_phase)
    i_hw_phase_step_select = 1'b0;
    wr(8'h10, 8'h7f);
    wt(600);
    `CHK("phase max", 8'h7f, o_coarse_output_phase)
    wr(8'h13, 8'haf);
    i_input_valid = 4'b1110;
    wt(3);
    `CHK("alarm raised", 1'b1, o_input_alarm[0])
    i_input_valid = 4'hf;
    wt(25);
    `CHK("alarm held", 1'b1, o_input_alarm[0])
    wt(10);
    `CHK("alarm cleared", 1'b0, o_input_alarm[0])
    i_phase_slip = 1'b1;
    wt(1);
    i_phase_slip = 1'b0;
    wt(2);
    `CHK("slip busy", 1'b1, o_slip_monitor_busy)
    wt(25);
    `CHK("slip idle", 1'b0, o_slip_monitor_busy)
    i_int_pin_route = 1'b1;
    i_int_status = 1'b1;
    i_input_fault = 3'b101;
    i_lock_loss = 1'b1;
    wt(3);
    `CHK("shared pin", 2'b11, {o_alarm_pin, o_alarm_pin_oe})
    `CHK("fault pins", 6'b101111, {o_fault_pin, o_fault_pin_oe})
    `CHK("lock pin", 2'b11, {o_lock_loss_pin, o_lock_loss_pin_oe})
    i_int_pin_route = 1'b0;
    wt(3);
    `CHK("alarm on pin", 2'b01, {o_alarm_pin, o_alarm_pin_oe})
    wr(8'h14, 8'h00);
    wt(3);
    `CHK("pins off", 4'h0, {o_alarm_pin_oe, o_fault_pin_oe})
    // Reset in mid-run brings the registers and pin enables back
    i_sys_rst = 1'b1;
    wt(2);
    i_sys_rst = 1'b0;
    rd(8'h14, q);
    `CHK("route after reset", 8'h3c, q)
    `CHK("reset pins", 5'b11110, {o_alarm_pin_oe, o_fault_pin_oe, o_lock_loss_pin_oe})
    rd(8'h11, q);
    `CHK("commit after reset", 8'h80, q)
    wrap_up();
  end
endmodule : sync_skew_latency_alarm_regs_tb
`default_nettype wire
